/* File: verilog/nco_pkg.sv */
package nco_pkg;

	// Register offsets on the APB bus, one aligned word each.
	localparam logic [7:0] OFF_CONTROL   = 8'h00;
	localparam logic [7:0] OFF_CLOCK_CFG = 8'h04;
	localparam logic [7:0] OFF_ACC_LOW   = 8'h08;
	localparam logic [7:0] OFF_ACC_HIGH  = 8'h0C;
	localparam logic [7:0] OFF_ACC_UPPER = 8'h10;
	localparam logic [7:0] OFF_INC_LOW   = 8'h14;
	localparam logic [7:0] OFF_INC_HIGH  = 8'h18;
	localparam logic [7:0] OFF_INC_UPPER = 8'h1C;
	localparam logic [7:0] OFF_IRQ_CTRL  = 8'h20;

	// Widths.
	localparam int ACC_W  = 20;
	localparam int BYTE_W = 8;
	localparam int UPPER_W = 4;
	localparam int PWS_W  = 3;
	localparam int CKS_W  = 2;
	localparam int PULSE_W = 8;

	// Control register fields.
	localparam int CTL_EN_BIT  = 7;
	localparam int CTL_OUT_BIT = 5;
	localparam int CTL_POL_BIT = 4;
	localparam int CTL_PFM_BIT = 0;

	// Clock configuration fields.
	localparam int CLK_PWS_LSB = 5;
	localparam int CLK_CKS_LSB = 0;

	// Interrupt control register fields.
	localparam int IRQ_FLAG_BIT = 0;
	localparam int IRQ_IE_BIT   = 1;
	localparam int IRQ_PE_BIT   = 2;
	localparam int IRQ_GE_BIT   = 3;

	// Clock source codes.
	localparam logic [1:0] CKS_FAST_OSC  = 2'h0;
	localparam logic [1:0] CKS_SYS_CLK   = 2'h1;
	localparam logic [1:0] CKS_LOGIC_LC3 = 2'h2;

	// Input clock edges from a low increment write to the buffer load.
	localparam logic [1:0] LOAD_EDGES = 2'h2;

	// Reset values.
	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [19:0] RST_WORD = 20'h00000;

endpackage : nco_pkg

/* File: verilog/nco_top.sv */
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ns

module nco_top (
	input  wire logic        pclk,          // APB clock, 10 MHz
	input  wire logic        presetn,       // Asynchronous reset, active low
	input  wire logic        psel,          // APB select
	input  wire logic        penable,       // APB access phase
	input  wire logic        pwrite,        // APB direction, high for write
	input  wire logic [7:0]  paddr,         // APB byte address
	input  wire logic [31:0] pwdata,        // APB write data
	output logic      [31:0] prdata,        // APB read data
	output logic             pready,        // APB ready
	output logic             pslverr,       // APB error on unmapped address
	input  wire logic        internal_fast_oscillator,    // Fast osc clock
	input  wire logic        logic_cell_three_output,     // Logic cell clock
	output logic             nco_out,                     // Final output
	output logic             nco_irq,                     // Gated interrupt
	output logic             fast_osc_keep_running        // Oscillator hold
);

	typedef struct packed {
		logic                        enable;
		logic                        invert;
		logic                        pulse_mode;
		logic [nco_pkg::PWS_W-1:0]   width_sel;
		logic [nco_pkg::CKS_W-1:0]   clk_sel;
		logic [nco_pkg::ACC_W-1:0]   acc;
		logic [nco_pkg::ACC_W-1:0]   inc_hold;
		logic [nco_pkg::ACC_W-1:0]   inc_buf;
		logic [1:0]                  load_pend;
		logic                        raw;
		logic [nco_pkg::PULSE_W-1:0] pulse_cnt;
		logic                        flag;
		logic                        irq_en;
		logic                        periph_en;
		logic                        global_en;
		logic [1:0]                  fast_sync;
		logic                        fast_prev;
		logic [1:0]                  cell_sync;
		logic                        cell_prev;
		logic                        rdy;
		logic                        err;
		logic [31:0]                 rdata;
		logic                        out_pin;
		logic                        irq;
		logic                        keep_osc;
	} nco_state_t;

	nco_state_t state_ff;
	nco_state_t nxt_state;

	logic                      access;
	logic                      wr_en;
	logic                      tick;
	logic                      carry;
	logic [nco_pkg::ACC_W-1:0] sum;
	logic                      acc_wr;
	logic                      inc_wr;
	logic                      inc_low_wr;

	// Read multiplexer; the hidden increment buffer has no address.
	function automatic logic [31:0] read_mux(input nco_state_t s,
		input logic [7:0] addr);
		logic [31:0] d;
		d = 32'h00000000;
		unique case (addr)
			nco_pkg::OFF_CONTROL:
			begin
				d[nco_pkg::CTL_EN_BIT]  = s.enable;
				d[nco_pkg::CTL_OUT_BIT] = s.out_pin;
				d[nco_pkg::CTL_POL_BIT] = s.invert;
				d[nco_pkg::CTL_PFM_BIT] = s.pulse_mode;
			end
			nco_pkg::OFF_CLOCK_CFG:
			begin
				d[nco_pkg::CLK_PWS_LSB +: nco_pkg::PWS_W] = s.width_sel;
				d[nco_pkg::CLK_CKS_LSB +: nco_pkg::CKS_W] = s.clk_sel;
			end
			nco_pkg::OFF_ACC_LOW:   d[7:0] = s.acc[7:0];
			nco_pkg::OFF_ACC_HIGH:  d[7:0] = s.acc[15:8];
			nco_pkg::OFF_ACC_UPPER: d[3:0] = s.acc[19:16];
			nco_pkg::OFF_INC_LOW:   d[7:0] = s.inc_hold[7:0];
			nco_pkg::OFF_INC_HIGH:  d[7:0] = s.inc_hold[15:8];
			nco_pkg::OFF_INC_UPPER: d[3:0] = s.inc_hold[19:16];
			nco_pkg::OFF_IRQ_CTRL:
			begin
				d[nco_pkg::IRQ_FLAG_BIT] = s.flag;
				d[nco_pkg::IRQ_IE_BIT]   = s.irq_en;
				d[nco_pkg::IRQ_PE_BIT]   = s.periph_en;
				d[nco_pkg::IRQ_GE_BIT]   = s.global_en;
			end
			default: d = 32'h00000000;
		endcase
		return d;
	endfunction : read_mux

	function automatic logic addr_hit(input logic [7:0] addr);
		return addr == nco_pkg::OFF_CONTROL || addr == nco_pkg::OFF_CLOCK_CFG
			|| addr == nco_pkg::OFF_ACC_LOW || addr == nco_pkg::OFF_ACC_HIGH
			|| addr == nco_pkg::OFF_ACC_UPPER || addr == nco_pkg::OFF_INC_LOW
			|| addr == nco_pkg::OFF_INC_HIGH || addr == nco_pkg::OFF_INC_UPPER
			|| addr == nco_pkg::OFF_IRQ_CTRL;
	endfunction : addr_hit

	// Active width minus one: 2**code periods, counted down to zero.
	function automatic logic [nco_pkg::PULSE_W-1:0] width_load(
		input logic [nco_pkg::PWS_W-1:0] code);
		logic [nco_pkg::PULSE_W-1:0] one;
		one = 8'h01;
		return (one << code) - 8'h01;
	endfunction : width_load

	assign access = psel & penable & state_ff.rdy;
	assign wr_en  = access & pwrite & addr_hit(paddr);

	// The system clock source ticks every cycle; the pin sources tick on a
	// rising edge seen after two synchroniser flops. A pin clock faster than
	// half of pclk therefore loses edges; that is the price of keeping
	// one clock domain.
	always_comb
	begin
		tick = 1'b0;
		if (state_ff.enable)
		begin
			unique case (state_ff.clk_sel)
				nco_pkg::CKS_FAST_OSC:
					tick = state_ff.fast_sync[1] & ~state_ff.fast_prev;
				nco_pkg::CKS_SYS_CLK:   tick = 1'b1;
				nco_pkg::CKS_LOGIC_LC3:
					tick = state_ff.cell_sync[1] & ~state_ff.cell_prev;
				default: tick = 1'b0;
			endcase
		end
	end

	assign {carry, sum} = {1'b0, state_ff.acc} + {1'b0, state_ff.inc_buf};

	assign acc_wr = wr_en && (paddr == nco_pkg::OFF_ACC_LOW
		|| paddr == nco_pkg::OFF_ACC_HIGH || paddr == nco_pkg::OFF_ACC_UPPER);
	assign inc_low_wr = wr_en && paddr == nco_pkg::OFF_INC_LOW;
	assign inc_wr = inc_low_wr || (wr_en && (paddr == nco_pkg::OFF_INC_HIGH
		|| paddr == nco_pkg::OFF_INC_UPPER));

	always_comb
	begin
		nxt_state = state_ff;

		// Synchronisers and edge history.
		nxt_state.fast_sync = {state_ff.fast_sync[0], internal_fast_oscillator};
		nxt_state.fast_prev = state_ff.fast_sync[1];
		nxt_state.cell_sync = {state_ff.cell_sync[0], logic_cell_three_output};
		nxt_state.cell_prev = state_ff.cell_sync[1];

		// Bus: one wait state, so pready and prdata come from flops.
		nxt_state.rdy   = psel & penable & ~state_ff.rdy;
		nxt_state.err   = 1'b0;
		nxt_state.rdata = 32'h00000000;
		if (psel & penable & ~state_ff.rdy)
		begin
			nxt_state.err = ~addr_hit(paddr);
			if (!pwrite)
				nxt_state.rdata = read_mux(state_ff, paddr);
		end

		// Engine, one step per input clock edge.
		if (tick)
		begin
			nxt_state.acc = sum;
			if (state_ff.load_pend == 2'h1)
			begin
				nxt_state.inc_buf   = state_ff.inc_hold;
				nxt_state.load_pend = 2'h0;
			end
			else if (state_ff.load_pend != 2'h0)
				nxt_state.load_pend = state_ff.load_pend - 2'h1;
			if (carry)
			begin
				nxt_state.flag = 1'b1;
				if (state_ff.pulse_mode)
				begin
					nxt_state.raw       = 1'b1;
					nxt_state.pulse_cnt = width_load(state_ff.width_sel);
				end
				else
					nxt_state.raw = ~state_ff.raw;
			end
			else if (state_ff.pulse_mode)
			begin
				// Width counting only in pulse mode.
				if (state_ff.pulse_cnt == 8'h00)
					nxt_state.raw = 1'b0;
				else
					nxt_state.pulse_cnt = state_ff.pulse_cnt - 8'h01;
			end
		end

		// A disabled module parks its output inactive.
		if (!state_ff.enable)
		begin
			nxt_state.raw       = 1'b0;
			nxt_state.pulse_cnt = 8'h00;
		end

		// Register writes; a written accumulator byte wins over the adder in the same cycle.
		if (wr_en)
		begin
			unique case (paddr)
				nco_pkg::OFF_CONTROL:
				begin
					nxt_state.enable     = pwdata[nco_pkg::CTL_EN_BIT];
					nxt_state.invert     = pwdata[nco_pkg::CTL_POL_BIT];
					nxt_state.pulse_mode = pwdata[nco_pkg::CTL_PFM_BIT];
					if (state_ff.irq_en
						&& pwdata[nco_pkg::CTL_POL_BIT] != state_ff.invert)
						nxt_state.flag = 1'b1;
				end
				nco_pkg::OFF_CLOCK_CFG:
				begin
					nxt_state.width_sel = pwdata[nco_pkg::CLK_PWS_LSB +: nco_pkg::PWS_W];
					nxt_state.clk_sel   = pwdata[nco_pkg::CLK_CKS_LSB +: nco_pkg::CKS_W];
				end
				nco_pkg::OFF_ACC_LOW:   nxt_state.acc[7:0]   = pwdata[7:0];
				nco_pkg::OFF_ACC_HIGH:  nxt_state.acc[15:8]  = pwdata[7:0];
				nco_pkg::OFF_ACC_UPPER: nxt_state.acc[19:16] = pwdata[3:0];
				nco_pkg::OFF_INC_LOW:   nxt_state.inc_hold[7:0]   = pwdata[7:0];
				nco_pkg::OFF_INC_HIGH:  nxt_state.inc_hold[15:8]  = pwdata[7:0];
				nco_pkg::OFF_INC_UPPER: nxt_state.inc_hold[19:16] = pwdata[3:0];
				nco_pkg::OFF_IRQ_CTRL:
				begin
					// A set raised in this cycle survives a clear.
					nxt_state.flag = nxt_state.flag
						& (pwdata[nco_pkg::IRQ_FLAG_BIT] | (tick & carry));
					nxt_state.irq_en    = pwdata[nco_pkg::IRQ_IE_BIT];
					nxt_state.periph_en = pwdata[nco_pkg::IRQ_PE_BIT];
					nxt_state.global_en = pwdata[nco_pkg::IRQ_GE_BIT];
				end
				default: nxt_state.err = 1'b0;
			endcase
		end

		// Increment buffer transfer depends on the enable at write time.
		if (inc_wr && !state_ff.enable)
		begin
			nxt_state.inc_buf   = nxt_state.inc_hold;
			nxt_state.load_pend = 2'h0;
		end
		else if (inc_low_wr)
			nxt_state.load_pend = nco_pkg::LOAD_EDGES;

		nxt_state.out_pin  = nxt_state.raw ^ nxt_state.invert;
		nxt_state.irq      = nxt_state.flag & nxt_state.enable
			& nxt_state.irq_en & nxt_state.periph_en & nxt_state.global_en;
		nxt_state.keep_osc = nxt_state.enable
			& (nxt_state.clk_sel == nco_pkg::CKS_FAST_OSC);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_ff <= '0;
		else
			state_ff <= nxt_state;
	end

	assign prdata                = state_ff.rdata;
	assign pready                = state_ff.rdy;
	assign pslverr               = state_ff.err;
	assign nco_out               = state_ff.out_pin;
	assign nco_irq               = state_ff.irq;
	assign fast_osc_keep_running = state_ff.keep_osc;

	sequence s_overflow;
		tick && carry;
	endsequence

	sequence s_pulse_end;
		tick && !carry && state_ff.pulse_mode && state_ff.raw
			&& state_ff.pulse_cnt == 8'h00;
	endsequence

	property p_acc_adds;
		@(posedge pclk) disable iff (!presetn)
		tick && !acc_wr |=> state_ff.acc
			== acc_mask(($past(state_ff.acc) + $past(state_ff.inc_buf)));
	endproperty
	a_acc_adds: assert property (p_acc_adds)
		else $error("accumulator did not add the increment");

	property p_flag_set;
		@(posedge pclk) disable iff (!presetn)
		s_overflow |=> state_ff.flag;
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("overflow did not set the flag");

	property p_fdc_toggle;
		@(posedge pclk) disable iff (!presetn)
		s_overflow ##0 (!state_ff.pulse_mode && !wr_en)
			|=> state_ff.raw != $past(state_ff.raw);
	endproperty
	a_fdc_toggle: assert property (p_fdc_toggle)
		else $error("fixed duty output did not toggle");

	property p_pf_start;
		@(posedge pclk) disable iff (!presetn)
		s_overflow ##0 (state_ff.pulse_mode && !wr_en) |=> state_ff.raw;
	endproperty
	a_pf_start: assert property (p_pf_start)
		else $error("pulse did not start on overflow");

	property p_pf_end;
		@(posedge pclk) disable iff (!presetn)
		s_pulse_end ##0 !wr_en |=> !state_ff.raw;
	endproperty
	a_pf_end: assert property (p_pf_end)
		else $error("pulse did not end after its width");

	property p_polarity;
		@(posedge pclk) disable iff (!presetn)
		nco_out == (state_ff.raw ^ state_ff.invert);
	endproperty
	a_polarity: assert property (p_polarity)
		else $error("output polarity stage wrong");

	property p_load_now;
		@(posedge pclk) disable iff (!presetn)
		inc_wr && !state_ff.enable |=> state_ff.inc_buf == state_ff.inc_hold;
	endproperty
	a_load_now: assert property (p_load_now)
		else $error("disabled increment write not loaded at once");

	property p_load_second;
		@(posedge pclk) disable iff (!presetn)
		tick && state_ff.load_pend == 2'h1 && !inc_wr && state_ff.enable
			|=> state_ff.inc_buf == $past(state_ff.inc_hold);
	endproperty
	a_load_second: assert property (p_load_second)
		else $error("increment buffer not loaded on second edge");

	property p_irq_gate;
		@(posedge pclk) disable iff (!presetn)
		nco_irq |-> state_ff.flag && state_ff.enable && state_ff.irq_en
			&& state_ff.periph_en && state_ff.global_en;
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("interrupt raised without all enables");

	property p_status_read;
		@(posedge pclk) disable iff (!presetn)
		psel && penable && !state_ff.rdy && !pwrite
			&& paddr == nco_pkg::OFF_CONTROL
			|=> prdata[nco_pkg::CTL_OUT_BIT] == $past(nco_out);
	endproperty
	a_status_read: assert property (p_status_read)
		else $error("status bit does not show output level");

	// Cuts the expected sum to the accumulator width, dropping the carry.
	function automatic logic [nco_pkg::ACC_W-1:0] acc_mask(
		input logic [nco_pkg::ACC_W-1:0] v);
		return v;
	endfunction : acc_mask

endmodule : nco_top

/* File: test/nco_peer.sv */
`timescale 1ns/1ns

// Stand-in for the clock sources feeding the oscillator. Each level lasts
// two pclk cycles, twice the shortest level the input synchroniser can see.
module nco_peer (
	input  wire logic pclk,     // System clock
	input  wire logic presetn,  // Reset, active low
	input  wire logic run,      // Clocks toggle only while high
	output logic      fast_osc, // Fast oscillator stand-in
	output logic      lc_out    // Logic cell output stand-in
);
	logic [1:0] div_ff;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_ff <= 2'h0;
		else if (run)
			div_ff <= div_ff + 2'h1;
	end

	assign fast_osc = div_ff[1];
	assign lc_out   = div_ff[1];
endmodule : nco_peer

/* File: test/testbench.sv */
`timescale 1ns/1ns

module testbench;
	localparam logic [7:0] A_CTL = nco_pkg::OFF_CONTROL;
	localparam logic [7:0] A_CLK = nco_pkg::OFF_CLOCK_CFG;
	localparam logic [7:0] A_ACC = nco_pkg::OFF_ACC_LOW;
	localparam logic [7:0] A_INC = nco_pkg::OFF_INC_LOW;
	localparam logic [7:0] A_IRQ = nco_pkg::OFF_IRQ_CTRL;

	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        fosc;
	logic        lcout;
	logic        nco_out;
	logic        nco_irq;
	logic        keep;
	logic        run;
	logic [31:0] rd;
	logic        err;
	int          n_mismatch;
	int          total_checks;
	int          cyc;
	int          hi;
	int          tg;

	nco_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .internal_fast_oscillator(fosc),
		.logic_cell_three_output(lcout), .nco_out(nco_out),
		.nco_irq(nco_irq), .fast_osc_keep_running(keep));

	nco_peer peer (.pclk(pclk), .presetn(presetn), .run(run),
		.fast_osc(fosc), .lc_out(lcout));

	initial
	begin
		pclk = 1'h0;
		forever #50 pclk = ~pclk;
	end

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : results

	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			n_mismatch++;
			results();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic rng(input string nm, input int lo, input int up,
		input int g);
		total_checks++;
		if (g < lo || g > up)
		begin
			n_mismatch++;
			$display("FAIL %s expected %0d..%0d seen %0d", nm, lo, up, g);
		end
	endtask : rng

	// The request stands until pready is sampled high at a rising edge;
	// read data and the error flag are taken at that same edge.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1 && n < 20)
		begin
			n++;
			@(posedge pclk);
		end
		if (n == 20)
			chk("pready", 32'h1, 32'h0);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'h1, a, d);
	endtask : wr

	task automatic rdc(input string nm, input logic [7:0] a,
		input logic [31:0] e);
		apb(1'h0, a, 8'h00);
		chk(nm, e, rd);
	endtask : rdc

	// Upper and high bytes go first so the low write moves a whole value.
	task automatic put3(input logic [7:0] a, input logic [19:0] v);
		wr(a + 8'h08, {4'h0, v[19:16]});
		wr(a + 8'h04, v[15:8]);
		wr(a, v[7:0]);
	endtask : put3

	task automatic watch(input int n);
		logic prev;
		hi = 0;
		tg = 0;
		@(negedge pclk);
		prev = nco_out;
		repeat (n)
		begin
			@(negedge pclk);
			if (nco_out === 1'h1)
				hi++;
			if (nco_out !== prev)
				tg++;
			prev = nco_out;
		end
	endtask : watch

	task automatic fin(input string nm);
		$display("test %s done", nm);
	endtask : fin

	initial
	begin
		presetn = 1'h0;
		psel    = 1'h0;
		penable = 1'h0;
		pwrite  = 1'h0;
		paddr   = 8'h00;
		pwdata  = 32'h00000000;
		run     = 1'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		for (int a = 0; a <= 32; a += 4)
			rdc("reset value", 8'(a), 32'h0);
		apb(1'h1, 8'h24, 8'hFF);
		chk("unmapped error", 32'h1, {31'h0, err});
		rdc("unmapped read", 8'h24, 32'h0);
		wr(A_CTL, 8'h20);
		rdc("status read only", A_CTL, 32'h0);
		fin("reset");

		put3(A_INC, 20'hFABCD);
		wr(A_INC + 8'h08, 8'hFF);
		rdc("inc upper", A_INC + 8'h08, 32'h0F);
		rdc("inc high", A_INC + 8'h04, 32'hAB);
		rdc("inc low", A_INC, 32'hCD);
		put3(A_ACC, 20'h51234);
		rdc("acc upper", A_ACC + 8'h08, 32'h05);
		rdc("acc high", A_ACC + 8'h04, 32'h12);
		rdc("acc low", A_ACC, 32'h34);
		fin("byte registers");

		put3(A_ACC, 20'h00000);
		put3(A_INC, 20'h80000);
		wr(A_CLK, 8'hE1);
		wr(A_CTL, 8'h80);
		watch(40);
		rng("fixed toggles", 19, 21, tg);
		rng("fixed high", 19, 21, hi);
		// A reload while running takes the new step a few ticks later.
		put3(A_INC, 20'h40000);
		watch(40);
		rng("reloaded toggles", 9, 11, tg);
		fin("fixed duty");

		// Width stays below the overflow period on every code.
		for (int p = 0; p < 8; p++)
		begin
			wr(A_CTL, 8'h00);
			wr(A_CLK, {3'(p), 5'h01});
			put3(A_ACC, 20'h00000);
			put3(A_INC, 20'h40000 >> p);
			wr(A_CTL, 8'h81);
			watch(32 << p);
			rng("pulse high", (8 << p) - (1 << p) - 1,
				(8 << p) + (1 << p) + 1, hi);
		end
		fin("pulse widths");

		wr(A_CTL, 8'h10);
		repeat (3) @(negedge pclk);
		chk("inverted idle", 32'h1, {31'h0, nco_out});
		rdc("status level", A_CTL, 32'h30);
		wr(A_CLK, 8'h01);
		put3(A_INC, 20'h40000);
		wr(A_CTL, 8'h91);
		watch(40);
		rng("inverted pulse", 29, 31, hi);
		fin("polarity");

		wr(A_CTL, 8'h00);
		wr(A_IRQ, 8'h0E);
		put3(A_INC, 20'h80000);
		wr(A_CTL, 8'h80);
		repeat (10) @(negedge pclk);
		chk("irq raised", 32'h1, {31'h0, nco_irq});
		wr(A_CTL, 8'h00);
		rdc("flag set", A_IRQ, 32'h0F);
		wr(A_IRQ, 8'h0E);
		rdc("flag cleared", A_IRQ, 32'h0E);
		chk("irq dropped", 32'h0, {31'h0, nco_irq});
		wr(A_CTL, 8'h10);
		rdc("polarity flag", A_IRQ, 32'h0F);
		wr(A_IRQ, 8'h06);
		wr(A_CTL, 8'h80);
		repeat (10) @(negedge pclk);
		chk("irq gated", 32'h0, {31'h0, nco_irq});
		rdc("flag no global", A_IRQ, 32'h07);
		fin("interrupt");

		wr(A_CTL, 8'h00);
		wr(A_IRQ, 8'h00);
		put3(A_ACC, 20'h00000);
		put3(A_INC, 20'h00001);
		wr(A_CLK, 8'h03);
		wr(A_CTL, 8'h80);
		repeat (20) @(negedge pclk);
		rdc("reserved source", A_ACC, 32'h0);
		chk("osc released", 32'h0, {31'h0, keep});
		for (int s = 2; s >= 0; s -= 2)
		begin
			wr(A_CTL, 8'h00);
			put3(A_ACC, 20'h00000);
			wr(A_CLK, 8'(s));
			@(posedge pclk);
			run <= 1'h1;
			wr(A_CTL, 8'h80);
			repeat (2) @(negedge pclk);
			chk("osc hold", {31'h0, s == 0}, {31'h0, keep});
			repeat (40) @(negedge pclk);
			wr(A_CTL, 8'h00);
			apb(1'h0, A_ACC, 8'h00);
			rng("pin ticks", 9, 13, int'(rd[7:0]));
		end
		fin("clock sources");
		results();
	end
endmodule : testbench
